// ===== spcc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module spcc_core_model #(
  parameter int OSC_DLY = 6
) (
  input wire logic clk_in,
  input wire logic osc_enable_in,
  input wire logic pclk_en_in,
  input wire logic cpu_clock_en_in,
  input wire logic fire_in,
  output logic osc_ready_out,
  output logic periph_irq_out
);
  int osc_cnt = 0;
  logic armed = 1'b0;
  initial osc_ready_out = 1'b1;
  initial periph_irq_out = 1'b0;
  // a restarted crystal is not usable at once
  always @(posedge clk_in) begin
    if (!osc_enable_in) begin
      osc_cnt <= 0;
      osc_ready_out <= 1'b0;
    end else if (osc_cnt < OSC_DLY) begin
      osc_cnt <= osc_cnt + 1;
    end else begin
      osc_ready_out <= 1'b1;
    end
  end
  // a timer peripheral: fires only on a live peripheral clock tick
  always @(posedge clk_in) begin
    if (fire_in) begin
      armed <= 1'b1;
    end else if (armed && pclk_en_in) begin
      armed <= 1'b0;
      periph_irq_out <= 1'b1;
    end else if (cpu_clock_en_in) begin
      periph_irq_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== spcc_pclk_div.sv
`timescale 1ns/1ps
`default_nettype none
module spcc_pclk_div
  import spcc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic run_in,
  input wire logic [1:0] sel_in,
  output logic pclk_en_out,
  output logic [1:0] active_out
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic [1:0] act_q;
  logic [1:0] act_d;
  logic [1:0] term;
  logic wrap;
  assign term = (act_q == SPCC_DIV_FULL) ? 2'h0 : (act_q == SPCC_DIV_HALF) ? 2'h1 : 2'h3;
  assign wrap = (cnt_q == term);
  assign cnt_d = wrap ? 2'h0 : cnt_q + 2'h1;
  // new ratio only at a period boundary, so no pulse is shortened
  assign act_d = (wrap && sel_in != 2'h3) ? sel_in : act_q;
  assign pclk_en_out = run_in && wrap;
  assign active_out = act_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 2'h0;
      act_q <= SPCC_DIV_RESET;
    end else if (run_in) begin
      cnt_q <= cnt_d;
      act_q <= act_d;
    end
  end
  AST_DIV_BOUNDARY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (act_q != $past(act_q)) |-> $past(wrap)) else $error("divider changed mid period");
endmodule
`default_nettype wire

// ===== spcc_pkg.sv
package spcc_pkg;
  localparam int SPCC_NUM_EXT = 9;
  localparam int SPCC_NUM_IRQ = 4;
  localparam int SPCC_NUM_PERIPH = 8;
  localparam int SPCC_AW = 4;
  // register byte offsets
  localparam logic [SPCC_AW-1:0] SPCC_ADDR_PWR = 4'h0;
  localparam logic [SPCC_AW-1:0] SPCC_ADDR_DIV = 4'h1;
  localparam logic [SPCC_AW-1:0] SPCC_ADDR_MAP = 4'h2;
  localparam logic [SPCC_AW-1:0] SPCC_ADDR_PGATE = 4'h3;
  localparam logic [SPCC_AW-1:0] SPCC_ADDR_EMODE = 4'h4;
  localparam logic [SPCC_AW-1:0] SPCC_ADDR_EWAKE = 4'h5;
  localparam logic [SPCC_AW-1:0] SPCC_ADDR_ESEL = 4'h6;
  localparam logic [SPCC_AW-1:0] SPCC_ADDR_STAT = 4'h7;
  localparam logic [SPCC_AW-1:0] SPCC_ADDR_CLR = 4'h8;
  localparam logic [SPCC_AW-1:0] SPCC_ADDR_IEN = 4'h9;
  localparam logic [SPCC_AW-1:0] SPCC_ADDR_STATE = 4'hA;
  localparam int SPCC_PWR_IDLE_BIT = 0;
  localparam int SPCC_PWR_PD_BIT = 1;
  // divider codes: 01 full rate, 10 half, 00 quarter
  localparam logic [1:0] SPCC_DIV_QUARTER = 2'h0;
  localparam logic [1:0] SPCC_DIV_FULL = 2'h1;
  localparam logic [1:0] SPCC_DIV_HALF = 2'h2;
  localparam logic [1:0] SPCC_DIV_RESET = SPCC_DIV_QUARTER;
  localparam logic SPCC_MAP_RESET = 1'b0;
  localparam logic [SPCC_NUM_PERIPH-1:0] SPCC_PGATE_RESET = 8'hFF;
  localparam int SPCC_STAT_W = 4;
  localparam int SPCC_ST_IDLE_BIT = 0;
  localparam int SPCC_ST_PD_BIT = 1;
  localparam int SPCC_ST_WAKE_BIT = 2;
  localparam int SPCC_ST_DIVCHG_BIT = 3;
  localparam int SPCC_WAKE_W = 16;
  localparam logic [SPCC_WAKE_W-1:0] SPCC_WAKE_CYCLES = 16'h0800;
  typedef enum logic [3:0] {
    SPCC_RUN = 4'h1,
    SPCC_IDLE = 4'h2,
    SPCC_PDOWN = 4'h4,
    SPCC_WAKE = 4'h8
  } spcc_state_t;
endpackage

// ===== spcc_top.sv
`timescale 1ns/1ps
`default_nettype none
module spcc_top
  import spcc_pkg::*;
#(
  parameter logic [SPCC_WAKE_W-1:0] WAKE_CYCLES = SPCC_WAKE_CYCLES
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [SPCC_AW-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic [SPCC_NUM_EXT-1:0] ext_irq_in,
  input wire logic periph_irq_in,
  input wire logic pll_on_in,
  input wire logic osc_ready_in,
  output logic [SPCC_NUM_IRQ-1:0] ext_req_out,
  output logic cpu_clock_en_out,
  output logic mem_bus_clk_en_out,
  output logic pclk_en_out,
  output logic [SPCC_NUM_PERIPH-1:0] periph_clk_en_out,
  output logic osc_enable_out,
  output logic pll_keep_out,
  output logic pin_hold_out,
  output logic map_ram_out,
  output logic irq_out
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  logic [SPCC_NUM_EXT-1:0] ext_s1_q;
  logic [SPCC_NUM_EXT-1:0] ext_s2_q;
  logic [SPCC_NUM_EXT-1:0] ext_prev_q;
  logic osc_s1_q;
  logic osc_s2_q;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_q <= '0;
      ext_s2_q <= '0;
      ext_prev_q <= '0;
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_irq_in;
      ext_s2_q <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
      osc_s1_q <= osc_ready_in;
      osc_s2_q <= osc_s1_q;
    end
  end

  logic [1:0] pwr_q;
  logic [1:0] div_q;
  logic map_q;
  logic [SPCC_NUM_PERIPH-1:0] pgate_q;
  logic [SPCC_NUM_EXT-1:0] emode_q;
  logic [SPCC_NUM_EXT-1:0] ewake_q;
  logic [2*SPCC_NUM_EXT-1:0] esel_q;
  logic [SPCC_NUM_EXT-1:0] eflag_q;
  logic [SPCC_STAT_W-1:0] stat_q;
  logic [SPCC_STAT_W-1:0] ien_q;
  logic [31:0] rdata_q;
  logic [SPCC_WAKE_W-1:0] wcnt_q;
  logic pll_was_on_q;
  spcc_state_t state_q;
  spcc_state_t state_d;

  logic wr_pwr, wr_div, wr_map, wr_pgate, wr_emode, wr_ewake, wr_esel, wr_clr, wr_ien;
  assign wr_pwr = wr_in && (addr_in == SPCC_ADDR_PWR);
  assign wr_div = wr_in && (addr_in == SPCC_ADDR_DIV);
  assign wr_map = wr_in && (addr_in == SPCC_ADDR_MAP);
  assign wr_pgate = wr_in && (addr_in == SPCC_ADDR_PGATE);
  assign wr_emode = wr_in && (addr_in == SPCC_ADDR_EMODE);
  assign wr_ewake = wr_in && (addr_in == SPCC_ADDR_EWAKE);
  assign wr_esel = wr_in && (addr_in == SPCC_ADDR_ESEL);
  assign wr_clr = wr_in && (addr_in == SPCC_ADDR_CLR);
  assign wr_ien = wr_in && (addr_in == SPCC_ADDR_IEN);

  // external inputs: rising edge or high level, per input mode
  logic [SPCC_NUM_EXT-1:0] ext_hit;
  logic [SPCC_NUM_IRQ-1:0] req_comb;
  genvar gi;
  generate
    for (gi = 0; gi < SPCC_NUM_EXT; gi++) begin : g_ext
      assign ext_hit[gi] = emode_q[gi] ? (ext_s2_q[gi] && !ext_prev_q[gi]) : ext_s2_q[gi];
    end
  endgenerate
  always_comb begin
    req_comb = '0;
    for (int i = 0; i < SPCC_NUM_EXT; i++) begin
      // edge flags are sticky; level inputs follow the pin
      if (emode_q[i] ? eflag_q[i] : ext_s2_q[i]) begin
        req_comb[esel_q[2*i +: 2]] = 1'b1;
      end
    end
  end
  logic [SPCC_NUM_EXT-1:0] eflag_d;
  assign eflag_d = (eflag_q & ~(wr_clr ? wdata_in[SPCC_STAT_W +: SPCC_NUM_EXT] : '0))
                 | (ext_hit & emode_q);

  // level-detected wake, taken from the clk_in synchronizer flops; gated by software enable
  logic pd_wake;
  assign pd_wake = |(ext_s2_q & ewake_q);
  logic any_irq;
  assign any_irq = periph_irq_in || (|req_comb);

  logic wake_done;
  assign wake_done = osc_s2_q && (wcnt_q >= WAKE_CYCLES);
  always_comb begin
    state_d = state_q;
    case (state_q)
      SPCC_RUN: begin
        if (wr_pwr && wdata_in[SPCC_PWR_PD_BIT]) begin
          state_d = SPCC_PDOWN;
        end else if (wr_pwr && wdata_in[SPCC_PWR_IDLE_BIT]) begin
          state_d = SPCC_IDLE;
        end
      end
      SPCC_IDLE: begin
        if (any_irq) begin
          state_d = SPCC_RUN;
        end
      end
      SPCC_PDOWN: begin
        if (pd_wake) begin
          state_d = SPCC_WAKE;
        end
      end
      SPCC_WAKE: begin
        if (wake_done) begin
          state_d = SPCC_RUN;
        end
      end
      default: state_d = SPCC_RUN;
    endcase
  end

  logic [SPCC_STAT_W-1:0] stat_set;
  logic div_changed;
  logic [1:0] div_active;
  assign stat_set[SPCC_ST_IDLE_BIT] = (state_q == SPCC_IDLE) && (state_d == SPCC_RUN);
  assign stat_set[SPCC_ST_PD_BIT] = (state_q == SPCC_PDOWN) && (state_d == SPCC_WAKE);
  assign stat_set[SPCC_ST_WAKE_BIT] = (state_q == SPCC_WAKE) && (state_d == SPCC_RUN);
  assign stat_set[SPCC_ST_DIVCHG_BIT] = div_changed;
  // set wins over a clear in the same cycle
  logic [SPCC_STAT_W-1:0] stat_d;
  assign stat_d = (stat_q & ~(wr_clr ? wdata_in[SPCC_STAT_W-1:0] : '0)) | stat_set;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SPCC_RUN;
      wcnt_q <= '0;
      pll_was_on_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wcnt_q <= (state_q == SPCC_WAKE) ? wcnt_q + 1'b1 : '0;
      if (state_q == SPCC_RUN) begin
        pll_was_on_q <= pll_on_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pwr_q <= 2'h0;
      div_q <= SPCC_DIV_RESET;
      map_q <= SPCC_MAP_RESET;
      pgate_q <= SPCC_PGATE_RESET;
      emode_q <= '0;
      ewake_q <= '0;
      esel_q <= '0;
      eflag_q <= '0;
      stat_q <= '0;
      ien_q <= '0;
    end else begin
      pwr_q <= (state_d == SPCC_RUN) ? 2'h0 : {state_d == SPCC_PDOWN, state_d == SPCC_IDLE};
      if (wr_div) div_q <= wdata_in[1:0];
      if (wr_map) map_q <= wdata_in[0];
      if (wr_pgate) pgate_q <= wdata_in[SPCC_NUM_PERIPH-1:0];
      if (wr_emode) emode_q <= wdata_in[SPCC_NUM_EXT-1:0];
      if (wr_ewake) ewake_q <= wdata_in[SPCC_NUM_EXT-1:0];
      if (wr_esel) esel_q <= wdata_in[2*SPCC_NUM_EXT-1:0];
      if (wr_ien) ien_q <= wdata_in[SPCC_STAT_W-1:0];
      eflag_q <= eflag_d;
      stat_q <= stat_d;
    end
  end

  logic [31:0] rd_mux;
  assign rd_mux = (addr_in == SPCC_ADDR_PWR) ? {30'h0, pwr_q} :
                  (addr_in == SPCC_ADDR_DIV) ? {30'h0, div_active} :
                  (addr_in == SPCC_ADDR_MAP) ? {31'h0, map_q} :
                  (addr_in == SPCC_ADDR_PGATE) ? {24'h0, pgate_q} :
                  (addr_in == SPCC_ADDR_EMODE) ? {23'h0, emode_q} :
                  (addr_in == SPCC_ADDR_EWAKE) ? {23'h0, ewake_q} :
                  (addr_in == SPCC_ADDR_ESEL) ? {14'h0, esel_q} :
                  (addr_in == SPCC_ADDR_STAT) ? {19'h0, eflag_q, stat_q} :
                  (addr_in == SPCC_ADDR_IEN) ? {28'h0, ien_q} :
                  (addr_in == SPCC_ADDR_STATE) ? {28'h0, state_q} : 32'h0;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rd_in ? rd_mux : 32'h0;
    end
  end

  logic div_run;
  logic [1:0] div_prev_q;
  assign div_run = (state_q == SPCC_RUN) || (state_q == SPCC_IDLE);
  spcc_pclk_div u_div (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .run_in(div_run),
    .sel_in(div_q),
    .pclk_en_out(pclk_en_out),
    .active_out(div_active)
  );
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      div_prev_q <= SPCC_DIV_RESET;
    end else begin
      div_prev_q <= div_active;
    end
  end
  assign div_changed = (div_prev_q != div_active);

  assign cpu_clock_en_out = (state_q == SPCC_RUN);
  assign mem_bus_clk_en_out = (state_q == SPCC_RUN);
  assign periph_clk_en_out = div_run ? pgate_q : '0;
  assign osc_enable_out = (state_q != SPCC_PDOWN);
  // core-side pll request drops in power-down; idle keeps the prior state
  assign pll_keep_out = (state_q == SPCC_IDLE) ? pll_was_on_q : (state_q == SPCC_RUN) && pll_on_in;
  assign pin_hold_out = (state_q == SPCC_PDOWN) || (state_q == SPCC_WAKE);
  assign map_ram_out = map_q;
  assign ext_req_out = req_comb;
  assign irq_out = |(stat_q & ien_q);
  assign rdata_out = rdata_q;

  AST_IDLE_WAKE: assert property (@(posedge clk_in) disable iff (!rst_n)
    (state_q == SPCC_IDLE && any_irq) |=> cpu_clock_en_out) else $error("idle not left on irq");
  AST_IDLE_PCLK: assert property (@(posedge clk_in) disable iff (!rst_n)
    (state_q == SPCC_IDLE) |-> (!cpu_clock_en_out && !mem_bus_clk_en_out && div_run)) else $error("idle gating");
  AST_PD_OSC: assert property (@(posedge clk_in) disable iff (!rst_n)
    (state_q == SPCC_PDOWN) |-> (!osc_enable_out && !pclk_en_out && periph_clk_en_out == '0)) else $error("pd clocks");
  AST_PD_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n)
    (state_q == SPCC_PDOWN) |=> $stable(map_q) && $stable(pgate_q) && pin_hold_out) else $error("pd state lost");
  AST_PD_EXIT: assert property (@(posedge clk_in) disable iff (!rst_n)
    (state_q == SPCC_PDOWN && pd_wake) |=> (state_q == SPCC_WAKE && !cpu_clock_en_out)) else $error("pd exit");
  AST_WAKE_TIMER: assert property (@(posedge clk_in) disable iff (!rst_n)
    ($past(state_q) == SPCC_PDOWN && state_q == SPCC_RUN) |-> 1'b0) else $error("wake timer skipped");
  AST_DIV_RESET: assert property (@(posedge clk_in)
    $rose(rst_n) |-> (div_q == SPCC_DIV_QUARTER)) else $error("divider reset value");
  AST_PGATE: assert property (@(posedge clk_in) disable iff (!rst_n)
    wr_pgate |=> (state_q == SPCC_PDOWN || periph_clk_en_out == $past(wdata_in[SPCC_NUM_PERIPH-1:0])))
    else $error("peripheral gate");
  AST_MAP: assert property (@(posedge clk_in) disable iff (!rst_n)
    wr_map |=> (map_ram_out == $past(wdata_in[0]))) else $error("vector map");
  AST_IDLE_ENTER: assert property (@(posedge clk_in) disable iff (!rst_n)
    (state_q == SPCC_RUN && wr_pwr && wdata_in[SPCC_PWR_IDLE_BIT] && !wdata_in[SPCC_PWR_PD_BIT])
    |=> (state_q == SPCC_IDLE && !cpu_clock_en_out)) else $error("idle not entered");
  AST_PD_ENTER: assert property (@(posedge clk_in) disable iff (!rst_n)
    (state_q == SPCC_RUN && wr_pwr && wdata_in[SPCC_PWR_PD_BIT])
    |=> (state_q == SPCC_PDOWN && !osc_enable_out)) else $error("power-down not entered");
  AST_PD_STAY: assert property (@(posedge clk_in) disable iff (!rst_n)
    (state_q == SPCC_PDOWN && !pd_wake) |=> (state_q == SPCC_PDOWN)) else $error("power-down left without wake");
  AST_WAKE_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n)
    (state_q == SPCC_WAKE && !wake_done) |=> (state_q == SPCC_WAKE && !cpu_clock_en_out))
    else $error("execution before oscillator stable");
  AST_WAKE_RUN: assert property (@(posedge clk_in) disable iff (!rst_n)
    (state_q == SPCC_WAKE && wake_done) |=> cpu_clock_en_out) else $error("wake timer never ends");
  AST_PLL_KEEP: assert property (@(posedge clk_in) disable iff (!rst_n)
    (state_q == SPCC_RUN && state_d == SPCC_IDLE && pll_on_in) |=> pll_keep_out)
    else $error("pll dropped in idle");
  AST_EXT_FLAG: assert property (@(posedge clk_in) disable iff (!rst_n)
    (|(ext_hit & emode_q)) |=> (|eflag_q)) else $error("edge flag lost");
endmodule
`default_nettype wire

// ===== system_power_clock_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module system_power_clock_control_bench
  import spcc_pkg::*;
;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [SPCC_AW-1:0] addr_in = '0;
  logic [31:0] wdata_in = '0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [SPCC_NUM_EXT-1:0] ext_irq_in = '0;
  logic pll_on_in = 1'b1;
  logic fire = 1'b0;
  wire logic periph_irq;
  wire logic osc_ready;
  logic [31:0] rdata_out;
  logic [SPCC_NUM_IRQ-1:0] ext_req_out;
  logic cpu_clock_en_out, mem_bus_clk_en_out, pclk_en_out, osc_enable_out;
  logic pll_keep_out, pin_hold_out, map_ram_out, irq_out;
  logic [SPCC_NUM_PERIPH-1:0] periph_clk_en_out;
  int bad_count = 0;
  int n_checks = 0;
  int n, mg, c;
  logic [1:0] dcode [3] = '{SPCC_DIV_HALF, SPCC_DIV_FULL, SPCC_DIV_QUARTER};
  int dcnt [3] = '{8, 16, 4};
  always #4 clk_in = ~clk_in;
  spcc_top #(.WAKE_CYCLES(16'h0004)) dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ext_irq_in(ext_irq_in),
    .periph_irq_in(periph_irq), .pll_on_in(pll_on_in), .osc_ready_in(osc_ready), .ext_req_out(ext_req_out),
    .cpu_clock_en_out(cpu_clock_en_out), .mem_bus_clk_en_out(mem_bus_clk_en_out), .pclk_en_out(pclk_en_out),
    .periph_clk_en_out(periph_clk_en_out), .osc_enable_out(osc_enable_out), .pll_keep_out(pll_keep_out),
    .pin_hold_out(pin_hold_out), .map_ram_out(map_ram_out), .irq_out(irq_out));
  spcc_core_model #(.OSC_DLY(6)) model_u (.clk_in(clk_in), .osc_enable_in(osc_enable_out),
    .pclk_en_in(pclk_en_out), .cpu_clock_en_in(cpu_clock_en_out), .fire_in(fire),
    .osc_ready_out(osc_ready), .periph_irq_out(periph_irq));
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [SPCC_AW-1:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [SPCC_AW-1:0] a, input logic [31:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata_out, e);
  endtask
  // spacing of peripheral ticks over a 16-cycle window
  task automatic pcount(output int cnt, output int gap);
    int last;
    cnt = 0;
    gap = 99;
    last = -1;
    for (int i = 0; i < 16; i++) begin
      tick();
      if (pclk_en_out === 1'b1) begin
        if (last >= 0 && i - last < gap) gap = i - last;
        last = i;
        cnt++;
      end
    end
  endtask
  task automatic wait_run(output int cyc);
    cyc = 0;
    while (cpu_clock_en_out !== 1'b1 && cyc < 200) begin
      tick();
      cyc++;
    end
  endtask
  task automatic results();
    if (bad_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    results();
  end
  initial begin
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(SPCC_ADDR_DIV, 32'h0);
    rd(SPCC_ADDR_MAP, 32'h0);
    rd(SPCC_ADDR_PGATE, 32'hFF);
    rd(SPCC_ADDR_STATE, 32'h1);
    rd(4'hF, 32'h0);
    pcount(n, mg);
    chk(n, 4);
    for (int k = 0; k < 3; k++) begin
      wr(SPCC_ADDR_DIV, {30'h0, dcode[k]});
      pcount(n, mg);
      if (k == 0) chk(mg, 2);
      pcount(n, mg);
      chk(n, dcnt[k]);
      rd(SPCC_ADDR_DIV, {30'h0, dcode[k]});
    end
    // reserved ratio code leaves the running ratio alone
    wr(SPCC_ADDR_DIV, 32'h3);
    pcount(n, mg);
    chk(n, 4);
    rd(SPCC_ADDR_DIV, 32'h0);
    wr(SPCC_ADDR_PGATE, 32'h5A);
    tick();
    chk(periph_clk_en_out, 32'h5A);
    wr(SPCC_ADDR_MAP, 32'h1);
    tick();
    chk(map_ram_out, 1);
    // idle: masked wake first, then unmask and clear the sticky bit
    wr(SPCC_ADDR_IEN, 32'h0);
    wr(SPCC_ADDR_CLR, 32'h1FFF);
    wr(SPCC_ADDR_PWR, 32'h1);
    tick();
    chk(cpu_clock_en_out, 0);
    chk(mem_bus_clk_en_out, 0);
    chk(pll_keep_out, 1);
    pcount(n, mg);
    chk(n, 4);
    @(posedge clk_in) fire <= 1'b1;
    @(posedge clk_in) fire <= 1'b0;
    wait_run(c);
    chk(c < 40, 1);
    rd(SPCC_ADDR_STAT, 32'h1);
    chk(irq_out, 0);
    wr(SPCC_ADDR_IEN, 32'h1);
    tick();
    chk(irq_out, 1);
    wr(SPCC_ADDR_CLR, 32'h1);
    tick();
    chk(irq_out, 0);
    // power-down: a pin without wake enable must not end it
    wr(SPCC_ADDR_ESEL, 32'h0);
    wr(SPCC_ADDR_EWAKE, 32'h1);
    wr(SPCC_ADDR_PWR, 32'h3);
    tick();
    chk(osc_enable_out, 0);
    chk(pin_hold_out, 1);
    chk(pll_keep_out, 0);
    pcount(n, mg);
    chk(n, 0);
    rd(SPCC_ADDR_STATE, 32'h4);
    rd(SPCC_ADDR_PWR, 32'h2);
    @(posedge clk_in) ext_irq_in <= 9'h008;
    repeat (8) tick();
    chk(cpu_clock_en_out, 0);
    @(posedge clk_in) ext_irq_in <= 9'h001;
    wait_run(c);
    chk(c >= 10 && c < 60, 1);
    chk(osc_enable_out, 1);
    chk(pin_hold_out, 0);
    chk(ext_req_out, 4'h1);
    chk(periph_clk_en_out, 32'h5A);
    rd(SPCC_ADDR_MAP, 32'h1);
    rd(SPCC_ADDR_STAT, 32'h6);
    // edge input stays flagged after the pin drops
    @(posedge clk_in) ext_irq_in <= 9'h000;
    wr(SPCC_ADDR_ESEL, 32'h8);
    wr(SPCC_ADDR_EMODE, 32'h2);
    @(posedge clk_in) ext_irq_in <= 9'h002;
    repeat (5) tick();
    chk(ext_req_out, 4'h4);
    @(posedge clk_in) ext_irq_in <= 9'h000;
    repeat (5) tick();
    chk(ext_req_out, 4'h4);
    rd(SPCC_ADDR_STAT, 32'h26);
    wr(SPCC_ADDR_CLR, 32'h20);
    tick();
    chk(ext_req_out, 4'h0);
    // reset in the middle of power-down restores every default
    wr(SPCC_ADDR_DIV, {30'h0, SPCC_DIV_HALF});
    pcount(n, mg);
    pcount(n, mg);
    chk(n, 8);
    wr(SPCC_ADDR_PWR, 32'h2);
    @(posedge clk_in) reset_n_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk(osc_enable_out, 1);
    chk(periph_clk_en_out, 32'hFF);
    rd(SPCC_ADDR_STATE, 32'h1);
    rd(SPCC_ADDR_DIV, 32'h0);
    rd(SPCC_ADDR_MAP, 32'h0);
    results();
  end
endmodule
`default_nettype wire
